/* File: hw/remote_local_command_control.v */
// How it works
// R1: Power-on self test blanks digits, lights lamps
// R2: Passing test enters preset sweep state
// R3: Failing test shows error in leftmost digit
// R4: Remote enable plus addressing enters remote
// R5: Remote settings change only from bus commands
// R6: Remote without lockout disables keys except local
// R7: Local key in plain remote returns local
// R8: Lockout command disables every key in remote, local too
// R9: Addressed go-to-local clears remote and lockout
// R10: Remote lamp lit in remote, dark local
// R11: Addressed data puts device remote, delivers bytes
// R12: Preset code enters remote and presets
// R13: Fixed-frequency code, decimal GHz, gigahertz suffix
// R14: Listened codes modify state like panel keys
// R15: Talk reports present state as byte
// R16: Local key equals go-to-local; bus-wide too
// R17: Address switches read only at power on
// R18: Ignore spaces, signs, junk; either letter case
// R19: On/off digit 1/0; register digit 1-9
// R20: Digits, one point, suffix commits value
`timescale 1ns/100ps
`include "rlcc_consts.vh"
module remote_local_command_control #(
  parameter SELFTEST_CYCLES = `SELFTEST_NS / `CLK_PERIOD_NS, // Shorten in simulation
  parameter FREQ_W          = 17                              // CW frequency width in MHz
)(
  input  wire              clk,
  input  wire              rst,
  input  wire              ren,              // Remote enable line, decoded
  input  wire              listen_addressed, // Device addressed to listen
  input  wire              talk_addressed,   // Device addressed to talk
  input  wire              llo_cmd,          // Local lockout command pulse
  input  wire              gtl_addr_cmd,     // Addressed go-to-local pulse
  input  wire              gtl_all_cmd,      // Bus-wide go-to-local pulse
  input  wire              rx_valid,         // Received data byte strobe
  input  wire [7:0]        rx_byte,          // Received data byte
  input  wire              tx_ready,         // Controller accepts a byte
  input  wire              selftest_ok,      // Result from test hardware
  input  wire              key_strobe,       // Front-panel key pin
  input  wire [2:0]        key_code,         // Front-panel key code pins
  input  wire [4:0]        key_value,        // Entered number pins
  input  wire [4:0]        addr_switch,      // Internal address switches
  output reg               remote_indicator_lamp,
  output reg               lockout_q,        // Local lockout in force
  output reg               panel_locked_q,   // Panel keys other than local have no effect
  output reg               display_blank_q,  // Numeric digits blanked
  output reg               lamp_test_q,      // All indicator lamps on
  output reg               error_display_q,  // Error code in leftmost digit
  output reg               preset_q,         // One-cycle preset to datapath
  output reg               cw_mode_q,        // Fixed frequency, not swept
  output reg [FREQ_W-1:0]  cw_freq_mhz_q,    // Fixed frequency in MHz
  output reg               rf_on_q,          // RF power on
  output reg               recall_q,         // One-cycle register recall
  output reg [3:0]         recall_reg_q,     // Register number 1 to 9
  output reg [4:0]         bus_addr_q,       // Address in effect
  output reg               tx_valid_q,       // Talk byte strobe
  output reg [7:0]         tx_byte_q         // Talk byte
);

  // Top-level sequencing states
  localparam [1:0] S_TEST = 2'h0;
  localparam [1:0] S_RUN  = 2'h1;
  localparam [1:0] S_FAIL = 2'h2;

  // Parser states
  localparam [2:0] P_IDLE = 3'h0; // Awaiting first letter
  localparam [2:0] P_L2   = 3'h1; // Awaiting second letter
  localparam [2:0] P_NUM  = 3'h2; // Numeric field
  localparam [2:0] P_UNIT = 3'h3; // Got G, awaiting Z
  localparam [2:0] P_ONOF = 3'h4; // Awaiting on/off digit
  localparam [2:0] P_REG  = 3'h5; // Awaiting register digit

  localparam PIN_W = 14;          // Strobe, code, value, switches

  reg  [1:0]       state_q;       // Sequencing state
  reg  [31:0]      test_cnt_q;    // Self-test timer
  reg              addr_taken_q;  // Switches already read
  reg  [PIN_W-1:0] pin_s1_q;      // First synchroniser stage
  reg  [PIN_W-1:0] pin_s2_q;      // Second synchroniser stage
  reg              key_prev_q;    // Strobe history for edge
  reg  [2:0]       pst_q;         // Parser state
  reg  [7:0]       first_q;       // First code letter
  reg  [9:0]       int_q;         // Whole GHz digits
  reg  [9:0]       frac_q;        // Fractional digits so far
  reg  [1:0]       fdig_q;        // Count of fractional digits
  reg              point_q;       // Decimal point seen
  reg              round_q;       // A fraction digit past the third >= 5
  reg              remote_d;      // Next remote state
  reg              lockout_d;     // Next lockout state

  // Synchronised pin fields, read only from the second stage
  wire             key_s   = pin_s2_q[13];
  wire [2:0]       code_s  = pin_s2_q[12:10];
  wire [4:0]       value_s = pin_s2_q[9:5];
  wire [4:0]       sw_s    = pin_s2_q[4:0];
  wire             key_evt = key_s & ~key_prev_q;
  wire             running = (state_q == S_RUN);
  wire [7:0]       ch      = upcase(rx_byte);
  wire             rx_take = rx_valid & listen_addressed & running;

  // Folds lower case onto upper case
  function [7:0] upcase;
    input [7:0] c;
    begin
      if (c >= `CH_LO_A && c <= `CH_LO_Z)
        upcase = c & ~`CH_CASE_BIT;
      else
        upcase = c;
    end
  endfunction

  function is_digit;
    input [7:0] c;
    begin
      is_digit = (c >= `CH_ZERO) && (c <= `CH_NINE);
    end
  endfunction

  function is_letter;
    input [7:0] c;
    begin
      is_letter = (c >= `CH_UP_A) && (c <= `CH_UP_Z);
    end
  endfunction

  // Fraction digits scaled to MHz by how many were typed
  function [9:0] frac_mhz;
    input [9:0] f;
    input [1:0] n;
    begin
      case (n)
        2'h1:    frac_mhz = f * 10'd100;
        2'h2:    frac_mhz = f * 10'd10;
        default: frac_mhz = f;
      endcase
    end
  endfunction

  // Full value in MHz; rounds up if any digit past the third fraction digit is >= 5
  wire [31:0] mhz_full = int_q * `MHZ_PER_GHZ + frac_mhz(frac_q, fdig_q) + round_q;
  wire [3:0]  digit    = ch[3:0];

  // Pins come from outside the clock domain: two stages first
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_q   <= {PIN_W{1'b0}};
      pin_s2_q   <= {PIN_W{1'b0}};
      key_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= {key_strobe, key_code, key_value, addr_switch};
      pin_s2_q   <= pin_s1_q;
      key_prev_q <= key_s;
    end
  end

  // Remote and lockout next state
  always @* begin
    remote_d  = remote_indicator_lamp;
    lockout_d = lockout_q;
    if (running) begin
      if (ren && listen_addressed)
        remote_d = 1'b1;                              // R4
      if (rx_take && ren)
        remote_d = 1'b1;                              // R11
      if (llo_cmd && ren)
        lockout_d = 1'b1;                             // R8
      // Local key only works while lockout is absent
      if (key_evt && code_s == `KEY_LOCAL && remote_indicator_lamp && !lockout_q)
        remote_d = 1'b0;                              // R7 R16
      if (gtl_addr_cmd) begin
        remote_d  = 1'b0;                             // R9
        lockout_d = 1'b0;                             // R9
      end
      if (gtl_all_cmd)
        remote_d = 1'b0;                              // R16
      // Dropping remote enable releases everything
      if (!ren) begin
        remote_d  = 1'b0;
        lockout_d = 1'b0;
      end
    end
  end

  // Sequencing, remote state, parser and instrument settings
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q               <= S_TEST;
      test_cnt_q            <= 32'h00000000;
      addr_taken_q          <= 1'b0;
      bus_addr_q            <= `RST_ADDR;
      remote_indicator_lamp <= 1'b0;
      lockout_q             <= 1'b0;
      panel_locked_q        <= 1'b1;
      display_blank_q       <= 1'b1;
      lamp_test_q           <= 1'b1;
      error_display_q       <= 1'b0;
      preset_q              <= 1'b0;
      cw_mode_q             <= 1'b0;
      cw_freq_mhz_q         <= `RST_CW_MHZ;
      rf_on_q               <= 1'b1;
      recall_q              <= 1'b0;
      recall_reg_q          <= 4'h0;
      pst_q                 <= P_IDLE;
      first_q               <= 8'h00;
      int_q                 <= 10'h000;
      frac_q                <= 10'h000;
      fdig_q                <= 2'h0;
      point_q               <= 1'b0;
      round_q               <= 1'b0;
    end else begin
      preset_q <= 1'b0;
      recall_q <= 1'b0;
      // Switches read once the synchroniser is full; needs SELFTEST_CYCLES > 1
      if (!addr_taken_q && test_cnt_q == `SYNC_FILL) begin
        addr_taken_q <= 1'b1;
        bus_addr_q   <= sw_s;                         // R17
      end
      case (state_q)
        S_TEST: begin
          // Digits dark, every lamp lit until the timer ends
          display_blank_q <= 1'b1;                    // R1
          lamp_test_q     <= 1'b1;                    // R1
          test_cnt_q      <= test_cnt_q + 32'h00000001;
          if (test_cnt_q >= SELFTEST_CYCLES - 1) begin
            lamp_test_q <= 1'b0;
            if (selftest_ok) begin
              state_q         <= S_RUN;
              display_blank_q <= 1'b0;
              preset_q        <= 1'b1;                // R2
              cw_mode_q       <= 1'b0;                // R2
              rf_on_q         <= 1'b1;
            end else begin
              state_q         <= S_FAIL;
              display_blank_q <= 1'b1;
              error_display_q <= 1'b1;                // R3
            end
          end
        end
        S_FAIL: begin
          // Stays here until power is cycled
          error_display_q <= 1'b1;                    // R3
          display_blank_q <= 1'b1;
        end
        S_RUN: begin
          remote_indicator_lamp <= remote_d;          // R10
          lockout_q             <= lockout_d;
          panel_locked_q        <= remote_d;          // R5 R6 R8
          // Panel keys act only in local
          if (key_evt && !remote_indicator_lamp) begin
            case (code_s)
              `KEY_PRESET: begin
                preset_q  <= 1'b1;
                cw_mode_q <= 1'b0;
                rf_on_q   <= 1'b1;
              end
              `KEY_ADDR:  bus_addr_q <= value_s;      // R17
              `KEY_RF:    rf_on_q    <= ~rf_on_q;
              `KEY_CW_UP: begin
                cw_mode_q     <= 1'b1;
                cw_freq_mhz_q <= cw_freq_mhz_q + {{(FREQ_W-1){1'b0}}, 1'b1};
              end
              default: ;
            endcase
          end
          // Bus bytes reach the parser only when listening
          if (rx_take) begin                          // R14
            case (pst_q)
              P_IDLE: begin
                if (is_letter(ch)) begin              // R18
                  first_q <= ch;
                  pst_q   <= P_L2;
                end
              end
              P_L2: begin
                if (is_letter(ch)) begin
                  pst_q <= P_IDLE;
                  if (first_q == `CH_I && ch == `CH_P) begin
                    preset_q  <= 1'b1;                // R12
                    cw_mode_q <= 1'b0;                // R12
                    rf_on_q   <= 1'b1;
                  end else if (first_q == `CH_C && ch == `CH_W) begin
                    pst_q   <= P_NUM;                 // R13
                    int_q   <= 10'h000;
                    frac_q  <= 10'h000;
                    fdig_q  <= 2'h0;
                    point_q <= 1'b0;
                    round_q <= 1'b0;
                  end else if (first_q == `CH_R && ch == `CH_E)
                    pst_q <= P_ONOF;
                  else if (first_q == `CH_R && ch == `CH_C)
                    pst_q <= P_REG;
                end
              end
              P_NUM: begin
                if (is_digit(ch)) begin
                  if (!point_q) begin
                    if (int_q < `INT_DIGIT_MAX)
                      int_q <= int_q * 10'd10 + {6'h00, digit}; // R20
                  end else if (fdig_q < `FRAC_DIGITS) begin
                    frac_q <= frac_q * 10'd10 + {6'h00, digit}; // R20
                    fdig_q <= fdig_q + 2'h1;
                  end else if (!round_q && fdig_q == `FRAC_DIGITS && digit >= 4'h5)
                    round_q <= 1'b1;
                end else if (ch == `CH_POINT)
                  point_q <= 1'b1;                    // R20
                else if (ch == `CH_G)
                  pst_q <= P_UNIT;
                else if (is_letter(ch)) begin
                  // Missing suffix: drop value, start a new code
                  first_q <= ch;
                  pst_q   <= P_L2;
                end
              end
              P_UNIT: begin
                if (ch == `CH_Z) begin
                  cw_mode_q     <= 1'b1;              // R13
                  cw_freq_mhz_q <= mhz_full[FREQ_W-1:0]; // R13 R20
                  pst_q         <= P_IDLE;
                end else if (is_letter(ch))
                  pst_q <= P_IDLE;
              end
              P_ONOF: begin
                if (ch == `CH_ONE || ch == `CH_ZERO) begin
                  rf_on_q <= (ch == `CH_ONE);         // R19
                  pst_q   <= P_IDLE;
                end else if (is_letter(ch))
                  pst_q <= P_IDLE;
              end
              P_REG: begin
                if (is_digit(ch) && ch != `CH_ZERO) begin
                  recall_q     <= 1'b1;               // R19
                  recall_reg_q <= digit;
                  pst_q        <= P_IDLE;
                end else if (is_letter(ch))
                  pst_q <= P_IDLE;
              end
              default: pst_q <= P_IDLE;
            endcase
          end
        end
        default: state_q <= S_TEST;
      endcase
    end
  end

  // Talk side: one status byte per accepted slot
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_valid_q <= 1'b0;
      tx_byte_q  <= 8'h00;
    end else begin
      tx_valid_q <= talk_addressed & tx_ready & ~tx_valid_q & (state_q != S_TEST); // R15
      tx_byte_q  <= 8'h00;
      tx_byte_q[`ST_REMOTE_BIT]  <= remote_indicator_lamp;
      tx_byte_q[`ST_LOCKOUT_BIT] <= lockout_q;
      tx_byte_q[`ST_CW_BIT]      <= cw_mode_q;
      tx_byte_q[`ST_RF_BIT]      <= rf_on_q;
      tx_byte_q[`ST_FAIL_BIT]    <= error_display_q;
    end
  end

endmodule // remote_local_command_control

/* File: hw/rlcc_consts.vh */
`ifndef RLCC_CONSTS_VH
`define RLCC_CONSTS_VH
// Clock and self-test timing
`define CLK_PERIOD_NS   5
`define SELFTEST_NS     100000
// Front-panel key codes
`define KEY_LOCAL       3'h1
`define KEY_PRESET      3'h2
`define KEY_ADDR        3'h3
`define KEY_RF          3'h4
`define KEY_CW_UP       3'h5
// ASCII characters the parser knows
`define CH_SPACE        8'h20
`define CH_PLUS         8'h2b
`define CH_MINUS        8'h2d
`define CH_POINT        8'h2e
`define CH_ZERO         8'h30
`define CH_NINE         8'h39
`define CH_ONE          8'h31
`define CH_UP_A         8'h41
`define CH_UP_Z         8'h5a
`define CH_LO_A         8'h61
`define CH_LO_Z         8'h7a
`define CH_CASE_BIT     8'h20
// Program-code letters
`define CH_C            8'h43
`define CH_E            8'h45
`define CH_G            8'h47
`define CH_I            8'h49
`define CH_P            8'h50
`define CH_R            8'h52
`define CH_W            8'h57
`define CH_Z            8'h5a
// Field layout of the talk status byte
`define ST_REMOTE_BIT   0
`define ST_LOCKOUT_BIT  1
`define ST_CW_BIT       2
`define ST_RF_BIT       3
`define ST_FAIL_BIT     4
// Reset values and numeric limits
`define RST_ADDR        5'h13
`define RST_CW_MHZ      17'h00000
`define MHZ_PER_GHZ     1000
`define INT_DIGIT_MAX   10'h00a
`define SYNC_FILL       32'h00000002
`define FRAC_DIGITS     2'h3
`endif

/* File: verif/bus_ctrl_model.sv */
`timescale 1ns/100ps
module bus_ctrl_model (
  input  wire       clk,
  input  wire       tx_valid,
  input  wire [7:0] tx_byte,
  output reg        ren,
  output reg        listen_addressed,
  output reg        talk_addressed,
  output reg        llo_cmd,
  output reg        gtl_addr_cmd,
  output reg        gtl_all_cmd,
  output reg        rx_valid,
  output reg  [7:0] rx_byte,
  output reg        tx_ready
);
  // Idle bus: nothing addressed
  initial begin
    {ren, listen_addressed, talk_addressed, tx_ready} = 4'h0;
    {llo_cmd, gtl_addr_cmd, gtl_all_cmd, rx_valid} = 4'h0;
    rx_byte = 8'h5a;
  end
  // Addressed output: enable, address, one byte per cycle
  task send_str(input string s);
    integer i;
    @(negedge clk);
    ren = 1'b1;
    listen_addressed = 1'b1;
    for (i = 0; i < s.len(); i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte = s[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte; // Released data never shows last byte
    listen_addressed = 1'b0;
  endtask
  // One-cycle command: 0 lockout, 1 addressed local, 2 bus-wide local
  task pulse(input integer k);
    @(negedge clk);
    llo_cmd = (k == 0);
    gtl_addr_cmd = (k == 1);
    gtl_all_cmd = (k == 2);
    @(negedge clk);
    {llo_cmd, gtl_addr_cmd, gtl_all_cmd} = 3'h0;
  endtask
  // Address to talk, take the first byte offered
  task read_status(output logic [7:0] b, output logic ok);
    ok = 1'b0;
    b = 8'h00;
    @(negedge clk);
    talk_addressed = 1'b1;
    tx_ready = 1'b1;
    repeat (10) begin
      @(negedge clk);
      if (!ok && tx_valid === 1'b1) begin
        b = tx_byte;
        ok = 1'b1;
      end
    end
    talk_addressed = 1'b0;
    tx_ready = 1'b0;
  endtask
endmodule // bus_ctrl_model

/* File: verif/remote_local_command_control_test.sv */
`timescale 1ns/100ps
`include "rlcc_consts.vh"
module remote_local_command_control_test;
  typedef struct { string s; logic [16:0] f; } row_t;
  row_t        rows [5];     // Command string and frequency it gives
  logic        clk, rst, selftest_ok, key_strobe;
  logic [2:0]  key_code;
  logic [4:0]  key_value, addr_switch;
  wire         ren, listen_addressed, talk_addressed, llo_cmd, gtl_addr_cmd;
  wire         gtl_all_cmd, rx_valid, tx_ready;
  wire  [7:0]  rx_byte, tx_byte_q;
  wire         remote_indicator_lamp, lockout_q, panel_locked_q, display_blank_q;
  wire         lamp_test_q, error_display_q, preset_q, cw_mode_q, rf_on_q;
  wire         recall_q, tx_valid_q;
  wire  [16:0] cw_freq_mhz_q;
  wire  [3:0]  recall_reg_q;
  wire  [4:0]  bus_addr_q;
  integer      err_total = 0, check_count = 0, preset_n = 0, recall_n = 0, i, n0;
  logic [3:0]  last_reg;    // Register of latest recall
  logic [7:0]  b;
  logic        ok;
  remote_local_command_control #(.SELFTEST_CYCLES(8), .FREQ_W(17)) dut (
    .clk(clk), .rst(rst), .ren(ren), .listen_addressed(listen_addressed),
    .talk_addressed(talk_addressed), .llo_cmd(llo_cmd), .gtl_addr_cmd(gtl_addr_cmd),
    .gtl_all_cmd(gtl_all_cmd), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_ready(tx_ready), .selftest_ok(selftest_ok), .key_strobe(key_strobe),
    .key_code(key_code), .key_value(key_value), .addr_switch(addr_switch),
    .remote_indicator_lamp(remote_indicator_lamp), .lockout_q(lockout_q),
    .panel_locked_q(panel_locked_q), .display_blank_q(display_blank_q),
    .lamp_test_q(lamp_test_q), .error_display_q(error_display_q), .preset_q(preset_q),
    .cw_mode_q(cw_mode_q), .cw_freq_mhz_q(cw_freq_mhz_q), .rf_on_q(rf_on_q),
    .recall_q(recall_q), .recall_reg_q(recall_reg_q), .bus_addr_q(bus_addr_q),
    .tx_valid_q(tx_valid_q), .tx_byte_q(tx_byte_q));
  bus_ctrl_model bc (
    .clk(clk), .tx_valid(tx_valid_q), .tx_byte(tx_byte_q), .ren(ren),
    .listen_addressed(listen_addressed), .talk_addressed(talk_addressed),
    .llo_cmd(llo_cmd), .gtl_addr_cmd(gtl_addr_cmd), .gtl_all_cmd(gtl_all_cmd),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pulses are one cycle wide, so count them at the edge
  always @(posedge clk) begin
    if (preset_q === 1'b1) preset_n <= preset_n + 1;
    if (recall_q === 1'b1) begin
      recall_n <= recall_n + 1;
      last_reg <= recall_reg_q;
    end
  end
  task chk(input logic [31:0] exp, input logic [31:0] got, input string nm);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task stop_test;
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Panel key press, held past the synchroniser, then a quiet gap
  task key(input logic [2:0] c);
    @(negedge clk);
    key_code = c;
    key_strobe = 1'b1;
    repeat (3) @(negedge clk);
    key_strobe = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  initial begin
    rows[0] = '{"CW7.555GZ", 17'h01d83};
    rows[1] = '{"cw 12.3gz", 17'h0300c};
    rows[2] = '{"CW+0.5GZ", 17'h001f4};
    rows[3] = '{"CW7.5555GZ", 17'h01d84};
    rows[4] = '{"CW2#.25GZ", 17'h008ca};
    {rst, selftest_ok, key_strobe} = 3'h6;
    key_code = 3'h0;
    key_value = 5'h00;
    addr_switch = 5'h0a;
    repeat (5) @(negedge clk);
    chk(1, display_blank_q, "blank");
    chk(1, lamp_test_q, "lamp_test");
    chk(5'h13, bus_addr_q, "bus_addr");
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 40 && display_blank_q !== 1'b0; i++) @(negedge clk);
    if (i == 40) begin
      err_total++;
      stop_test;
    end
    repeat (2) @(negedge clk);
    chk(1, preset_n, "preset count");
    chk(0, lamp_test_q, "lamp_test");
    chk(5'h0a, bus_addr_q, "bus_addr");
    foreach (rows[k]) begin
      bc.send_str(rows[k].s);
      @(negedge clk);
      chk(rows[k].f, cw_freq_mhz_q, "cw_freq");
      chk(1, cw_mode_q, "cw_mode");
      chk(1, remote_indicator_lamp, "remote");
    end
    bc.read_status(b, ok);
    chk(1, ok, "talk");
    chk(8'h0d, b, "status");
    key(`KEY_RF);
    chk(1, rf_on_q, "rf_on");
    key(`KEY_LOCAL);
    chk(0, remote_indicator_lamp, "remote");
    key(`KEY_RF);
    chk(0, rf_on_q, "rf_on");
    bc.send_str("RE1");
    chk(1, rf_on_q, "rf_on");
    bc.send_str("re0");
    chk(0, rf_on_q, "rf_on");
    bc.pulse(0);
    @(negedge clk);
    chk(1, lockout_q, "lockout");
    key(`KEY_LOCAL);
    chk(1, remote_indicator_lamp, "remote");
    key(`KEY_RF);
    chk(0, rf_on_q, "rf_on");
    bc.pulse(1);
    @(negedge clk);
    chk(0, remote_indicator_lamp, "remote");
    chk(0, lockout_q, "lockout");
    n0 = preset_n;
    bc.send_str("IP");
    @(negedge clk);
    chk(n0 + 1, preset_n, "preset count");
    chk(0, cw_mode_q, "cw_mode");
    chk(1, remote_indicator_lamp, "remote");
    bc.pulse(2);
    @(negedge clk);
    chk(0, remote_indicator_lamp, "remote");
    key(`KEY_CW_UP);
    chk(17'h008cb, cw_freq_mhz_q, "cw_freq");
    chk(1, cw_mode_q, "cw_mode");
    n0 = preset_n;
    key(`KEY_PRESET);
    chk(n0 + 1, preset_n, "preset count");
    chk(0, cw_mode_q, "cw_mode");
    n0 = recall_n;
    bc.send_str("RC5");
    @(negedge clk);
    chk(n0 + 1, recall_n, "recall count");
    chk(4'h5, last_reg, "recall_reg");
    n0 = preset_n;
    key(`KEY_PRESET);
    chk(n0, preset_n, "preset count");
    addr_switch = 5'h1f;
    repeat (4) @(negedge clk);
    chk(5'h0a, bus_addr_q, "bus_addr");
    bc.pulse(1);
    key_value = 5'h07;
    key(`KEY_ADDR);
    chk(5'h07, bus_addr_q, "bus_addr");
    n0 = preset_n;
    selftest_ok = 1'b0;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 40 && error_display_q !== 1'b1; i++) @(negedge clk);
    if (i == 40) begin
      err_total++;
      stop_test;
    end
    repeat (3) @(negedge clk);
    chk(1, error_display_q, "error_display");
    chk(1, display_blank_q, "blank");
    chk(n0, preset_n, "preset count");
    chk(5'h1f, bus_addr_q, "bus_addr");
    stop_test;
  end
endmodule // remote_local_command_control_test
bind remote_local_command_control rlcc_checker #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .ren(ren), .listen_addressed(listen_addressed),
  .talk_addressed(talk_addressed), .llo_cmd(llo_cmd), .gtl_addr_cmd(gtl_addr_cmd),
  .gtl_all_cmd(gtl_all_cmd), .tx_ready(tx_ready),
  .remote_indicator_lamp(remote_indicator_lamp), .lockout_q(lockout_q),
  .panel_locked_q(panel_locked_q), .display_blank_q(display_blank_q),
  .lamp_test_q(lamp_test_q), .error_display_q(error_display_q), .preset_q(preset_q),
  .tx_valid_q(tx_valid_q));

/* File: verif/rlcc_checker.sv */
`timescale 1ns/100ps
module rlcc_checker #(
  parameter SELFTEST_CYCLES = 8
)(
  input wire clk,
  input wire rst,
  input wire ren,
  input wire listen_addressed,
  input wire talk_addressed,
  input wire llo_cmd,
  input wire gtl_addr_cmd,
  input wire gtl_all_cmd,
  input wire tx_ready,
  input wire remote_indicator_lamp,
  input wire lockout_q,
  input wire panel_locked_q,
  input wire display_blank_q,
  input wire lamp_test_q,
  input wire error_display_q,
  input wire preset_q,
  input wire tx_valid_q
);
  integer st_cnt; // Cycles spent in self test
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Count test cycles; a stuck test would grow it past the bound
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_cnt <= 0;
    end else if (display_blank_q && !error_display_q) begin
      st_cnt <= st_cnt + 1;
    end
  end
  a_selftest_bound: assert property (st_cnt <= SELFTEST_CYCLES + 3)
    else $error("self test too long");
  a_blank_lamps: assert property (!error_display_q |-> display_blank_q == lamp_test_q)
    else $error("blank and lamp test differ");
  a_pass_preset: assert property ($fell(display_blank_q) |-> ##[0:1] preset_q)
    else $error("no preset after test");
  a_fail_frozen: assert property (error_display_q |-> display_blank_q && !preset_q)
    else $error("fail state not frozen");
  a_remote_on_addr: assert property (!display_blank_q && ren && listen_addressed
    && !gtl_addr_cmd && !gtl_all_cmd |=> remote_indicator_lamp)
    else $error("remote not entered");
  a_panel_locked: assert property (!display_blank_q && !$past(display_blank_q)
    |-> panel_locked_q == remote_indicator_lamp)
    else $error("panel lock differs from remote");
  a_llo_sets: assert property (!display_blank_q && ren && llo_cmd && remote_indicator_lamp
    && !gtl_addr_cmd && !gtl_all_cmd |=> lockout_q)
    else $error("lockout not set");
  a_gtl_clears: assert property (!display_blank_q && gtl_addr_cmd
    |=> !remote_indicator_lamp && !lockout_q)
    else $error("go to local ignored");
  a_ren_low: assert property (!display_blank_q && !ren
    |=> !remote_indicator_lamp && !lockout_q)
    else $error("remote without enable");
  a_preset_pulse: assert property (preset_q |=> !preset_q)
    else $error("preset longer than a cycle");
  a_tx_spacing: assert property (tx_valid_q |=> !tx_valid_q)
    else $error("talk strobe too long");
  a_tx_cause: assert property (tx_valid_q |-> $past(talk_addressed && tx_ready))
    else $error("talk byte unasked");
  a_gtl_all: assert property (!display_blank_q && gtl_all_cmd |=> !remote_indicator_lamp)
    else $error("bus-wide local ignored");
endmodule // rlcc_checker
